// File: hw/ipc_cfg.svh
// Behaviour
// [RULE1] Three-bit priority field; 111 masks user interrupts
// [RULE2] Upper bit above field forms effective level
// [RULE3] Field is read-only while nesting disabled
// [RULE4] Upper bit shows level above seven; clear-only
// [RULE5] Nesting disable bit in primary control
// [RULE6] Trap events set four trap status bits
// [RULE7] Alternate vector table select bit
// [RULE8] Timed disable status bit, read-only
// [RULE9] Edge polarity selects edge per external input
// [RULE10] Conversion-done flag at bank bit 13
// [RULE11] Serial transmit bit 12, receive bit 11
// [RULE12] Sync serial event bit 10, fault 9
// [RULE13] Timer flags at bits 8, 7, 3
// [RULE14] Compare and capture flags at 6,5,2,1
// [RULE15] External input zero flag at bit 0
// [RULE16] Unimplemented bits read zero, ignore writes
// [RULE17] All implemented bits clear at reset
// [RULE18] Sources set flags; software clears them
// [RULE19] Software can never set the upper bit
// [RULE20] Request only above effective priority level
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define IPC_ADDR_W       12
`define IPC_OFS_STATUS   12'h000
`define IPC_OFS_CORE     12'h004
`define IPC_OFS_CTRL1    12'h008
`define IPC_OFS_CTRL2    12'h00C
`define IPC_OFS_FLAGS0   12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IPC_SR_IPL_LSB   5
`define IPC_SR_IPL_MSB   7
`define IPC_CC_UPPER_BIT 3
`define IPC_IC1_NEST_BIT 15
`define IPC_IC1_TRAP_LSB 1
`define IPC_IC1_TRAP_MSB 4
`define IPC_IC2_ALT_BIT  15
`define IPC_IC2_TIMED_DISABLE_ACTIVE_BIT 14
`define IPC_IC2_POL_LSB  0
`define IPC_IC2_POL_MSB  2
`define IPC_FLG_ADC      13
`define IPC_FLG_SER1_TX  12
`define IPC_FLG_SER1_RX  11
`define IPC_FLG_SYN1_EV  10
`define IPC_FLG_SYN1_FLT 9
`define IPC_FLG_TMR3     8
`define IPC_FLG_TMR2     7
`define IPC_FLG_CMP2     6
`define IPC_FLG_CAP2     5
`define IPC_FLG_TMR1     3
`define IPC_FLG_CMP1     2
`define IPC_FLG_CAP1     1
`define IPC_FLG_EXT0     0
`define IPC_NUM_SRC      16
`define IPC_PRIO_W       3
`define IPC_LVL_W        4
`define IPC_VEC_W        4

// ----------------------------------------
// Values
// ----------------------------------------
`define IPC_IPL_ALL_OFF  3'h7
`define IPC_RST_FIELD    3'h0
`define IPC_RST_BIT      1'h0
`define IPC_RST_TRAPS    4'h0
`define IPC_RST_POL      3'h0
`define IPC_RST_FLAGS    16'h0000
`define IPC_RST_VEC      4'h0
`define IPC_RST_WORD     32'h0000_0000
`define IPC_ZERO16       16'h0000

`endif

// File: hw/ipc_pkg.sv
`include "ipc_cfg.svh"

package ipc_pkg;

    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`IPC_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
    } ipc_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ipc_apb_rsp_type;

    typedef struct packed {
        logic                   irq_req;
        logic [`IPC_VEC_W-1:0]  irq_vec;
        logic                   alt_vector_select;
        logic [`IPC_LVL_W-1:0]  eff_level;
        logic                   nesting_disable;
        logic [2:0]             ext_edge;
    } ipc_core_out_type;

    typedef struct packed {
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
        logic [2:0]             cpu_priority_field;
        logic                   priority_upper_bit;
        logic                   nesting_disable;
        logic [3:0]             trap_flags;
        logic                   alt_vector_select;
        logic                   timed_disable_active;
        logic [2:0]             ext_edge_polarity;
        logic [15:0]            flags;
        logic [2:0]             sync1;
        logic [2:0]             sync2;
        logic [2:0]             ext_prev;
        logic [2:0]             ext_edge;
        logic                   irq_req;
        logic [`IPC_VEC_W-1:0]  irq_vec;
    } ipc_state_type;

endpackage : ipc_pkg

// File: hw/ipc_regs.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ipc_cfg.svh"

module ipc_regs (
    // Clock and control
    input  wire logic                              clk,
    input  wire logic                              srst,
    input  wire logic                              clk_en,
    // Register bus
    input  wire ipc_pkg::ipc_apb_req_type          apb_req,
    output var  ipc_pkg::ipc_apb_rsp_type          apb_rsp,
    // Peripheral and trap sources, one-cycle pulses
    input  wire logic [`IPC_NUM_SRC-1:0]           src_events,
    input  wire logic [3:0]                        trap_events,
    // External interrupt pins, asynchronous
    input  wire logic [2:0]                        ext_pins,
    // CPU core side
    input  wire logic                              timed_disable_in,
    input  wire logic                              cpu_ipl_load,
    input  wire logic [`IPC_LVL_W-1:0]             cpu_ipl_value,
    input  wire logic                              cpu_in_isr,
    input  wire logic [`IPC_NUM_SRC-1:0]           irq_enable,
    input  wire logic [`IPC_NUM_SRC*`IPC_PRIO_W-1:0] irq_priority,
    // Core-facing results
    output var  ipc_pkg::ipc_core_out_type         core_out
);

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam logic [15:0] FLAG_MASK =
        (16'h0001 << `IPC_FLG_ADC)     | (16'h0001 << `IPC_FLG_SER1_TX) | // RULE10 RULE11
        (16'h0001 << `IPC_FLG_SER1_RX) | (16'h0001 << `IPC_FLG_SYN1_EV) | // RULE11 RULE12
        (16'h0001 << `IPC_FLG_SYN1_FLT)| (16'h0001 << `IPC_FLG_TMR3)    | // RULE12 RULE13
        (16'h0001 << `IPC_FLG_TMR2)    | (16'h0001 << `IPC_FLG_TMR1)    | // RULE13
        (16'h0001 << `IPC_FLG_CMP2)    | (16'h0001 << `IPC_FLG_CAP2)    | // RULE14
        (16'h0001 << `IPC_FLG_CMP1)    | (16'h0001 << `IPC_FLG_CAP1)    | // RULE14
        (16'h0001 << `IPC_FLG_EXT0);                                      // RULE15

    function automatic logic [`IPC_PRIO_W-1:0] prio_of(
        input logic [`IPC_NUM_SRC*`IPC_PRIO_W-1:0] bus,
        input logic [`IPC_VEC_W-1:0]               v
    );
        prio_of = bus[v*`IPC_PRIO_W +: `IPC_PRIO_W];
    endfunction : prio_of

    // ----------------------------------------
    // State
    // ----------------------------------------
    ipc_pkg::ipc_state_type state_reg;
    ipc_pkg::ipc_state_type state_next;

    logic                  setup_ph;
    logic                  wr_en;
    logic                  addr_hit;
    logic [15:0]           rd_word;
    logic [15:0]           wd;
    logic [2:0]            edge_seen;
    logic [`IPC_LVL_W-1:0] eff_level;
    logic [15:0]           pending;
    logic                  found;
    logic [`IPC_PRIO_W-1:0] best_prio;
    logic [`IPC_VEC_W-1:0] best_vec;

    assign wd        = apb_req.pwdata[15:0];
    assign setup_ph  = apb_req.psel & ~apb_req.penable;
    assign wr_en     = apb_req.psel & apb_req.penable & apb_req.pwrite & state_reg.pready;
    assign eff_level = {state_reg.priority_upper_bit, state_reg.cpu_priority_field}; // RULE2

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb begin
        rd_word  = `IPC_ZERO16;
        addr_hit = 1'b1;
        case (apb_req.paddr)
            `IPC_OFS_STATUS: begin
                rd_word[`IPC_SR_IPL_MSB:`IPC_SR_IPL_LSB] = state_reg.cpu_priority_field; // RULE1
            end
            `IPC_OFS_CORE: begin
                rd_word[`IPC_CC_UPPER_BIT] = state_reg.priority_upper_bit; // RULE4
            end
            `IPC_OFS_CTRL1: begin
                rd_word[`IPC_IC1_NEST_BIT] = state_reg.nesting_disable; // RULE5
                rd_word[`IPC_IC1_TRAP_MSB:`IPC_IC1_TRAP_LSB] = state_reg.trap_flags; // RULE6
            end
            `IPC_OFS_CTRL2: begin
                rd_word[`IPC_IC2_ALT_BIT]  = state_reg.alt_vector_select; // RULE7
                rd_word[`IPC_IC2_TIMED_DISABLE_ACTIVE_BIT] = state_reg.timed_disable_active; // RULE8
                rd_word[`IPC_IC2_POL_MSB:`IPC_IC2_POL_LSB] = state_reg.ext_edge_polarity; // RULE9
            end
            `IPC_OFS_FLAGS0: begin
                rd_word = state_reg.flags & FLAG_MASK; // RULE16
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;

        // Bus slave: answer in the first access cycle
        state_next.pready = setup_ph & ~state_reg.pready;
        if (setup_ph) begin
            state_next.prdata  = {16'h0000, rd_word};
            state_next.pslverr = ~addr_hit;
        end else begin
            state_next.prdata  = `IPC_RST_WORD;
            state_next.pslverr = 1'b0;
        end

        // External pin synchroniser and edge detect
        state_next.sync1    = ext_pins;
        state_next.sync2    = state_reg.sync1;
        state_next.ext_prev = state_reg.sync2;
        edge_seen = (state_reg.sync2 & ~state_reg.ext_prev & ~state_reg.ext_edge_polarity) |
                    (~state_reg.sync2 & state_reg.ext_prev & state_reg.ext_edge_polarity); // RULE9
        state_next.ext_edge = edge_seen;

        // Status mirror from the core
        state_next.timed_disable_active = timed_disable_in; // RULE8

        // Software writes
        if (wr_en) begin
            case (apb_req.paddr)
                `IPC_OFS_STATUS: begin
                    if (!state_reg.nesting_disable) begin // RULE3
                        state_next.cpu_priority_field = wd[`IPC_SR_IPL_MSB:`IPC_SR_IPL_LSB];
                    end
                end
                `IPC_OFS_CORE: begin
                    // Writing zero clears; writing one is ignored
                    if (!wd[`IPC_CC_UPPER_BIT]) begin // RULE4 RULE19
                        state_next.priority_upper_bit = 1'b0;
                    end
                end
                `IPC_OFS_CTRL1: begin
                    state_next.nesting_disable = wd[`IPC_IC1_NEST_BIT]; // RULE5
                    state_next.trap_flags = wd[`IPC_IC1_TRAP_MSB:`IPC_IC1_TRAP_LSB];
                end
                `IPC_OFS_CTRL2: begin
                    state_next.alt_vector_select = wd[`IPC_IC2_ALT_BIT]; // RULE7
                    state_next.ext_edge_polarity = wd[`IPC_IC2_POL_MSB:`IPC_IC2_POL_LSB];
                end
                `IPC_OFS_FLAGS0: begin
                    state_next.flags = wd & FLAG_MASK; // RULE16 RULE18
                end
                default: begin
                    state_next.flags = state_next.flags;
                end
            endcase
        end

        // Core level load wins over software
        if (cpu_ipl_load) begin
            state_next.priority_upper_bit = cpu_ipl_value[`IPC_LVL_W-1];
            state_next.cpu_priority_field = cpu_ipl_value[`IPC_PRIO_W-1:0];
        end

        // Hardware sets win over software clears
        state_next.trap_flags = state_next.trap_flags | trap_events; // RULE6
        state_next.flags = state_next.flags | (src_events & FLAG_MASK); // RULE18
        if (edge_seen[0]) begin
            state_next.flags[`IPC_FLG_EXT0] = 1'b1; // RULE15
        end

        // Arbitration: highest priority, lowest vector on a tie
        pending   = state_reg.flags & irq_enable & FLAG_MASK;
        found     = 1'b0;
        best_prio = 3'h0;
        best_vec  = `IPC_RST_VEC;
        for (int i = 0; i < `IPC_NUM_SRC; i++) begin
            if (pending[i] && (!found || prio_of(irq_priority, i[3:0]) > best_prio)) begin
                found     = 1'b1;
                best_prio = prio_of(irq_priority, i[3:0]);
                best_vec  = i[3:0];
            end
        end
        // Level seven or above blocks every user source
        state_next.irq_req = found && ({1'b0, best_prio} > eff_level) && // RULE20 RULE1
                             !(state_reg.nesting_disable && cpu_in_isr); // RULE5
        state_next.irq_vec = best_vec;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg.pready               <= 1'b0;
            state_reg.pslverr              <= 1'b0;
            state_reg.prdata               <= `IPC_RST_WORD;
            state_reg.cpu_priority_field   <= `IPC_RST_FIELD; // RULE17
            state_reg.priority_upper_bit   <= `IPC_RST_BIT;
            state_reg.nesting_disable      <= `IPC_RST_BIT;
            state_reg.trap_flags           <= `IPC_RST_TRAPS;
            state_reg.alt_vector_select    <= `IPC_RST_BIT;
            state_reg.timed_disable_active <= `IPC_RST_BIT;
            state_reg.ext_edge_polarity    <= `IPC_RST_POL;
            state_reg.flags                <= `IPC_RST_FLAGS;
            state_reg.sync1                <= 3'h0;
            state_reg.sync2                <= 3'h0;
            state_reg.ext_prev             <= 3'h0;
            state_reg.ext_edge             <= 3'h0;
            state_reg.irq_req              <= 1'b0;
            state_reg.irq_vec              <= `IPC_RST_VEC;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign apb_rsp.prdata             = state_reg.prdata;
    assign apb_rsp.pready             = state_reg.pready;
    assign apb_rsp.pslverr            = state_reg.pslverr;
    assign core_out.irq_req           = state_reg.irq_req;
    assign core_out.irq_vec           = state_reg.irq_vec;
    assign core_out.alt_vector_select = state_reg.alt_vector_select; // RULE7
    assign core_out.eff_level         = {state_reg.priority_upper_bit,
                                         state_reg.cpu_priority_field}; // RULE2
    assign core_out.nesting_disable   = state_reg.nesting_disable;
    assign core_out.ext_edge          = state_reg.ext_edge;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic wr_sr;
    logic wr_cc;
    assign wr_sr = wr_en && apb_req.paddr == `IPC_OFS_STATUS;
    assign wr_cc = wr_en && apb_req.paddr == `IPC_OFS_CORE;

    a_field_locked: assert property ( // RULE3
        clk_en && wr_sr && state_reg.nesting_disable && !cpu_ipl_load
        |=> $stable(state_reg.cpu_priority_field))
        else $error("priority field changed while locked");

    a_field_written: assert property ( // RULE1
        clk_en && wr_sr && !state_reg.nesting_disable && !cpu_ipl_load
        |=> state_reg.cpu_priority_field == $past(wd[`IPC_SR_IPL_MSB:`IPC_SR_IPL_LSB]))
        else $error("priority field write lost");

    a_upper_no_set: assert property ( // RULE19
        clk_en && !state_reg.priority_upper_bit && !cpu_ipl_load
        |=> !state_reg.priority_upper_bit)
        else $error("upper level bit set without core load");

    a_upper_clear: assert property ( // RULE4
        clk_en && wr_cc && !wd[`IPC_CC_UPPER_BIT] && !cpu_ipl_load
        |=> !state_reg.priority_upper_bit)
        else $error("upper level bit not cleared");

    a_flag_set_wins: assert property ( // RULE18
        clk_en && (src_events & FLAG_MASK) != 16'h0000
        |=> (state_reg.flags & $past(src_events & FLAG_MASK)) == $past(src_events & FLAG_MASK))
        else $error("source event lost");

    a_unimpl_zero: assert property ( // RULE16
        (state_reg.flags & ~FLAG_MASK) == 16'h0000)
        else $error("unimplemented flag bit set");

    a_trap_set: assert property ( // RULE6
        clk_en && trap_events != 4'h0
        |=> (state_reg.trap_flags & $past(trap_events)) == $past(trap_events))
        else $error("trap event lost");

    a_ext0_edge: assert property ( // RULE9
        clk_en && state_reg.sync2[0] != state_reg.ext_prev[0] &&
        state_reg.sync2[0] != state_reg.ext_edge_polarity[0]
        |=> state_reg.flags[`IPC_FLG_EXT0])
        else $error("external edge missed");

    a_timed_disable_active_mirror: assert property ( // RULE8
        clk_en |=> state_reg.timed_disable_active == $past(timed_disable_in))
        else $error("timed disable status stale");

    a_irq_strict: assert property ( // RULE20
        $past(clk_en) && state_reg.irq_req
        |-> {1'b0, prio_of($past(irq_priority), state_reg.irq_vec)} > $past(eff_level))
        else $error("request not above current level");

    a_apb_answer: assert property (
        clk_en && setup_ph |=> apb_rsp.pready ##1 (!$past(clk_en) || !apb_rsp.pready))
        else $error("bus answer not one cycle");

    c_irq_raised: cover property (state_reg.irq_req);
    c_locked_write: cover property (clk_en && wr_sr && state_reg.nesting_disable);
    c_set_and_clear: cover property (
        clk_en && wr_en && apb_req.paddr == `IPC_OFS_FLAGS0 && src_events != 16'h0000);
    c_unmapped: cover property (apb_rsp.pready && apb_rsp.pslverr);

endmodule : ipc_regs
`default_nettype wire

// File: hw/ipc_unused_guard.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: verification/ipc_src_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipc_cfg.svh"

module ipc_src_model (
    // Clock
    input  wire logic                                clk,
    // Peripheral, trap and pin sources
    output var  logic [`IPC_NUM_SRC-1:0]             src_events,
    output var  logic [3:0]                          trap_events,
    output var  logic [2:0]                          ext_pins,
    // CPU core side
    output var  logic                                timed_disable_in,
    output var  logic                                cpu_ipl_load,
    output var  logic [`IPC_LVL_W-1:0]               cpu_ipl_value,
    output var  logic                                cpu_in_isr,
    output var  logic [`IPC_NUM_SRC-1:0]             irq_enable,
    output var  logic [`IPC_NUM_SRC*`IPC_PRIO_W-1:0] irq_priority
);
    initial begin
        src_events       = '0;
        trap_events      = '0;
        ext_pins         = '0;
        timed_disable_in = 1'b0;
        cpu_ipl_load     = 1'b0;
        cpu_ipl_value    = '0;
        cpu_in_isr       = 1'b0;
        irq_enable       = '0;
        irq_priority     = '0;
    end

    // ----------------------------------------
    // One-cycle event pulses
    // ----------------------------------------
    task automatic pulse(input logic [15:0] s, input logic [3:0] t, input logic ld,
                         input logic [3:0] lv);
        @(posedge clk);
        src_events    <= s;
        trap_events   <= t;
        cpu_ipl_load  <= ld;
        cpu_ipl_value <= lv;
        @(posedge clk);
        src_events    <= '0;
        trap_events   <= '0;
        cpu_ipl_load  <= 1'b0;
    endtask : pulse

    // ----------------------------------------
    // Level inputs
    // ----------------------------------------
    task automatic set_lvl(input logic [2:0] p, input logic td, input logic isr,
                           input logic [15:0] en, input logic [47:0] pr);
        @(posedge clk);
        ext_pins         <= p;
        timed_disable_in <= td;
        cpu_in_isr       <= isr;
        irq_enable       <= en;
        irq_priority     <= pr;
    endtask : set_lvl
endmodule : ipc_src_model
`default_nettype wire

// File: verification/test_interrupt_priority_control_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipc_cfg.svh"

module test_interrupt_priority_control_regs;
    localparam logic [15:0] FLAG_MASK = 16'h3FEF;
    logic                          clk = 1'b0;
    logic                          srst = 1'b1;
    logic                          clk_en = 1'b1;
    ipc_pkg::ipc_apb_req_type      req = '0;
    ipc_pkg::ipc_apb_rsp_type      rsp;
    ipc_pkg::ipc_core_out_type     cout;
    logic [15:0]                   src_events;
    logic [3:0]                    trap_events;
    logic [2:0]                    ext_pins;
    logic                          tdi;
    logic                          ipl_load;
    logic [3:0]                    ipl_value;
    logic                          in_isr;
    logic [15:0]                   irq_en;
    logic [47:0]                   irq_pri;
    int                            err_count = 0;
    int                            comparisons = 0;
    int                            cycles = 0;
    int                            edge_cnt = 0;
    int                            base;

    ipc_regs u_dut (.clk(clk), .srst(srst), .clk_en(clk_en), .apb_req(req),
        .apb_rsp(rsp), .src_events(src_events), .trap_events(trap_events),
        .ext_pins(ext_pins), .timed_disable_in(tdi), .cpu_ipl_load(ipl_load),
        .cpu_ipl_value(ipl_value), .cpu_in_isr(in_isr), .irq_enable(irq_en),
        .irq_priority(irq_pri), .core_out(cout));

    ipc_src_model u_src (.clk(clk), .src_events(src_events), .trap_events(trap_events),
        .ext_pins(ext_pins), .timed_disable_in(tdi), .cpu_ipl_load(ipl_load),
        .cpu_ipl_value(ipl_value), .cpu_in_isr(in_isr), .irq_enable(irq_en),
        .irq_priority(irq_pri));

    initial begin
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        edge_cnt <= edge_cnt + $countones(cout.ext_edge);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    function automatic void check(string nm, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endfunction : check

    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                        input logic [15:0] e, input logic xe, input string nm);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {16'h0000, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        check("pready", 32'h1, {31'h0, rsp.pready});
        if (!w) check(nm, {16'h0000, e}, rsp.prdata);
        check("pslverr", {31'h0, xe}, {31'h0, rsp.pslverr});
        req <= '0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        xfer(1'b1, a, d, 16'h0000, 1'b0, "write");
    endtask : wr

    task automatic rd(input string nm, input logic [11:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000, e, 1'b0, nm);
    endtask : rd

    task automatic chk_irq(input logic [15:0] sv, input logic ex);
        wr(`IPC_OFS_STATUS, sv);
        repeat (3) @(posedge clk);
        check("irq_req", {31'h0, ex}, {31'h0, cout.irq_req});
        if (ex) check("irq_vec", 32'h3, {28'h0, cout.irq_vec});
    endtask : chk_irq

    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd("status", `IPC_OFS_STATUS, 16'h0000);
        rd("core", `IPC_OFS_CORE, 16'h0000);
        rd("ctrl1", `IPC_OFS_CTRL1, 16'h0000);
        rd("ctrl2", `IPC_OFS_CTRL2, 16'h0000);
        rd("flags", `IPC_OFS_FLAGS0, 16'h0000);
        xfer(1'b0, 12'h014, 16'h0000, 16'h0000, 1'b1, "unmapped");
        wr(`IPC_OFS_STATUS, 16'hFFFF);
        rd("status", `IPC_OFS_STATUS, 16'h00E0);
        check("eff_level", 32'h7, {28'h0, cout.eff_level});
        wr(`IPC_OFS_CORE, 16'hFFFF);
        rd("core", `IPC_OFS_CORE, 16'h0000);
        wr(`IPC_OFS_CTRL1, 16'hFFFF);
        rd("ctrl1", `IPC_OFS_CTRL1, 16'h801E);
        check("nest", 32'h1, {31'h0, cout.nesting_disable});
        wr(`IPC_OFS_STATUS, 16'h0000);
        rd("status", `IPC_OFS_STATUS, 16'h00E0);
        wr(`IPC_OFS_CTRL1, 16'h0000);
        wr(`IPC_OFS_STATUS, 16'h0000);
        rd("status", `IPC_OFS_STATUS, 16'h0000);
        wr(`IPC_OFS_CTRL2, 16'hFFFF);
        rd("ctrl2", `IPC_OFS_CTRL2, 16'h8007);
        check("alt", 32'h1, {31'h0, cout.alt_vector_select});
        wr(`IPC_OFS_CTRL2, 16'h0000);
        wr(`IPC_OFS_FLAGS0, 16'hFFFF);
        rd("flags", `IPC_OFS_FLAGS0, FLAG_MASK);
        wr(`IPC_OFS_FLAGS0, 16'h0000);
        clk_en <= 1'b0;
        u_src.pulse(16'h0002, 4'h0, 1'b0, 4'h0);
        clk_en <= 1'b1;
        rd("frozen", `IPC_OFS_FLAGS0, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            u_src.pulse(16'h0001 << i, 4'h0, 1'b0, 4'h0);
            repeat (4) @(posedge clk);
            rd("flags", `IPC_OFS_FLAGS0, FLAG_MASK & (16'h0001 << i));
            wr(`IPC_OFS_FLAGS0, 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            u_src.pulse(16'h0000, 4'h1 << i, 1'b0, 4'h0);
            rd("ctrl1", `IPC_OFS_CTRL1, 16'h0002 << i);
            wr(`IPC_OFS_CTRL1, 16'h0000);
        end
        u_src.set_lvl(3'h0, 1'b1, 1'b0, 16'h0000, 48'h0);
        wr(`IPC_OFS_CTRL2, 16'h0000);
        rd("ctrl2", `IPC_OFS_CTRL2, 16'h4000);
        u_src.set_lvl(3'h0, 1'b0, 1'b0, 16'h0000, 48'h0);
        repeat (3) @(posedge clk);
        rd("ctrl2", `IPC_OFS_CTRL2, 16'h0000);
        u_src.pulse(16'h0000, 4'h0, 1'b1, 4'hF);
        rd("core", `IPC_OFS_CORE, 16'h0008);
        rd("status", `IPC_OFS_STATUS, 16'h00E0);
        check("eff_level", 32'hF, {28'h0, cout.eff_level});
        wr(`IPC_OFS_CORE, 16'h0000);
        rd("core", `IPC_OFS_CORE, 16'h0000);
        wr(`IPC_OFS_STATUS, 16'h0000);
        base = edge_cnt;
        u_src.set_lvl(3'h7, 1'b0, 1'b0, 16'h0000, 48'h0);
        repeat (6) @(posedge clk);
        rd("flags", `IPC_OFS_FLAGS0, 16'h0001);
        check("edges_rise", 32'd3, edge_cnt - base);
        wr(`IPC_OFS_CTRL2, 16'h0007);
        repeat (6) @(posedge clk);
        wr(`IPC_OFS_FLAGS0, 16'h0000);
        base = edge_cnt;
        u_src.set_lvl(3'h0, 1'b0, 1'b0, 16'h0000, 48'h0);
        repeat (6) @(posedge clk);
        rd("flags", `IPC_OFS_FLAGS0, 16'h0001);
        check("edges_fall", 32'd3, edge_cnt - base);
        wr(`IPC_OFS_FLAGS0, 16'h0000);
        base = edge_cnt;
        u_src.set_lvl(3'h7, 1'b0, 1'b0, 16'h0000, 48'h0);
        repeat (6) @(posedge clk);
        rd("flags", `IPC_OFS_FLAGS0, 16'h0000);
        check("edges_none", 32'd0, edge_cnt - base);
        u_src.set_lvl(3'h7, 1'b0, 1'b0, 16'h0008, 48'h0000_0000_0800);
        u_src.pulse(16'h0008, 4'h0, 1'b0, 4'h0);
        chk_irq(16'h0060, 1'b1);
        chk_irq(16'h0080, 1'b0);
        u_src.set_lvl(3'h7, 1'b0, 1'b1, 16'h0008, 48'h0000_0000_0E00);
        chk_irq(16'h00E0, 1'b0);
        chk_irq(16'h00C0, 1'b1);
        wr(`IPC_OFS_CTRL1, 16'h8000);
        chk_irq(16'h00C0, 1'b0);
        wr(`IPC_OFS_CTRL1, 16'h0000);
        u_src.pulse(16'h0000, 4'h0, 1'b1, 4'h8);
        chk_irq(16'h0000, 1'b0);
        wr(`IPC_OFS_CORE, 16'h0000);
        chk_irq(16'h0000, 1'b1);
        give_verdict();
    end
endmodule : test_interrupt_priority_control_regs
`default_nettype wire
